/* rtl/dma_arbiter_chain_transfer.sv */
// multi-channel dma engine with priority arbiter and descriptor chaining
`include "dma_chain_defines.svh"
module dma_arbiter_chain_transfer
    import dma_chain_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // memory master
    output logic mem_cyc_o,
    output logic mem_stb_o,
    output logic mem_we_o,
    output logic mem_master_o,
    output logic [31:0] mem_adr_o,
    output logic [31:0] mem_dat_o,
    input wire logic [31:0] mem_dat_i,
    input wire logic mem_ack_i,
    input wire logic mem_err_i,
    // peripheral requests and interrupt
    input wire logic [15:0] dreq_i,
    output logic irq_o
);

    // ==========================================================
    // helpers
    function automatic logic [31:0] bmask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : bmask

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [31:0] m);
        return (old & ~m) | (d & m);
    endfunction : wmerge

    function automatic logic [31:0] step_addr(input logic [31:0] a, input logic [1:0] mode);
        if (mode == `AM_INC) begin
            return a + `WORD_STEP;
        end else if (mode == `AM_DEC) begin
            return a - `WORD_STEP;
        end
        return a;
    endfunction : step_addr

    function automatic logic [7:0] elig_f(input chan_t [7:0] ch, input logic [15:0] rq);
        logic [7:0] e;
        e = 8'h00;
        for (int i = 0; i < `NUM_CH; i++) begin
            e[i] = ch[i].cfg[`CFG_EN] & ~ch[i].ctrl[`CTL_ABT]
                 & (~ch[i].ctrl[`CTL_HW] | rq[ch[i].cfg[`CFG_REQ +: 4]]);
        end
        return e;
    endfunction : elig_f

    // priority then round robin
    // scanning from the channel after the last grant with a strict compare keeps
    // the first equal-priority channel in rotation order
    function automatic logic [3:0] arb_f(input logic [7:0] e, input chan_t [7:0] ch,
                                         input logic [2:0] last);
        logic found;
        logic [1:0] best;
        logic [2:0] idx;
        logic [2:0] i;
        found = 1'b0;
        best = 2'h0;
        idx = 3'h0;
        for (int k = 1; k <= `NUM_CH; k++) begin
            i = 3'(int'(last) + k);
            if (e[i] && (!found || ch[i].cfg[`CFG_PRI +: 2] > best)) begin
                found = 1'b1;
                best = ch[i].cfg[`CFG_PRI +: 2];
                idx = i;
            end
        end
        return {found, idx};
    endfunction : arb_f

    function automatic logic [1:0] maxpri_f(input logic [7:0] e, input chan_t [7:0] ch);
        logic [1:0] m;
        m = 2'h0;
        for (int i = 0; i < `NUM_CH; i++) begin
            if (e[i] && ch[i].cfg[`CFG_PRI +: 2] > m) begin
                m = ch[i].cfg[`CFG_PRI +: 2];
            end
        end
        return m;
    endfunction : maxpri_f

    function automatic logic [31:0] rd_f(input dma_state_t s, input logic [11:0] a);
        chan_t c;
        c = s.ch[a[7:5]];
        if (a == `TC_STAT_OFS) begin
            return {24'h000000, s.tc};
        end else if (a == `EA_STAT_OFS) begin
            return {16'h0000, s.ea};
        end else if (a[11:8] == `CH_REGION) begin
            unique case (a[4:0])
                `CH_CTRL_OFS: return c.ctrl;
                `CH_CFG_OFS: return c.cfg;
                `CH_SRC_OFS: return c.src;
                `CH_DST_OFS: return c.dst;
                `CH_NXT_OFS: return c.nxt;
                `CH_SIZE_OFS: return c.size;
                default: return 32'h00000000;
            endcase
        end
        return 32'h00000000;
    endfunction : rd_f

    // ==========================================================
    // state
    dma_state_t r;
    dma_state_t n;
    logic wb_req;
    logic [31:0] bm;
    logic [2:0] wc;
    logic [7:0] elig;
    logic [3:0] arb_res;
    logic [2:0] c;
    logic [3:0] cur_cnt;
    logic mdone_ok;

    assign wb_req = wb_cyc_i & wb_stb_i;
    assign bm = bmask(wb_sel_i);
    assign wc = wb_adr_i[7:5];
    assign elig = elig_f(r.ch, r.dreq);
    assign arb_res = arb_f(elig, r.ch, r.last);
    assign c = r.cur;
    assign cur_cnt = r.ch[r.cur].cfg[`CFG_CNT +: 4];
    assign mdone_ok = r.m_cyc & mem_ack_i & ~mem_err_i;

    // ==========================================================
    // next state
    always_comb begin : comb_p
        logic stop_e;
        logic mdone;
        stop_e = 1'b0;
        mdone = 1'b0;
        n = r;
        // answer one cycle after the request; write lands on the acknowledged edge
        n.wb_ack = wb_req & ~r.wb_ack;
        n.wb_dat = rd_f(r, wb_adr_i);
        if (wb_req && r.wb_ack && wb_we_i) begin
            if (wb_adr_i == `TC_CLR_OFS) begin
                n.tc = r.tc & ~(wb_dat_i[7:0] & bm[7:0]);
            end else if (wb_adr_i == `EA_CLR_OFS) begin
                n.ea = r.ea & ~(wb_dat_i[15:0] & bm[15:0]);
            end else if (wb_adr_i[11:8] == `CH_REGION) begin
                unique case (wb_adr_i[4:0])
                    `CH_CTRL_OFS: n.ch[wc].ctrl = wmerge(r.ch[wc].ctrl, wb_dat_i, bm & `CTL_WMASK);
                    `CH_CFG_OFS: begin
                        n.ch[wc].cfg = wmerge(r.ch[wc].cfg, wb_dat_i, bm & `CFG_WMASK);
                        if (!r.ch[wc].cfg[`CFG_EN] && n.ch[wc].cfg[`CFG_EN]) begin
                            n.ch[wc].cfg[`CFG_CNT +: 4] = 4'h0;
                        end
                    end
                    `CH_SRC_OFS: n.ch[wc].src = wmerge(r.ch[wc].src, wb_dat_i, bm);
                    `CH_DST_OFS: n.ch[wc].dst = wmerge(r.ch[wc].dst, wb_dat_i, bm);
                    `CH_NXT_OFS: n.ch[wc].nxt = wmerge(r.ch[wc].nxt, wb_dat_i, bm);
                    `CH_SIZE_OFS: n.ch[wc].size = wmerge(r.ch[wc].size, wb_dat_i, bm & `SIZE_WMASK);
                    default: ;
                endcase
            end
        end

        // request pins: a level counts once the second and third stage agree
        n.s1 = dreq_i;
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.dreq = ((r.s2 & r.s3) | (r.dreq & (r.s2 ^ r.s3))) & `REQ_VALID;

        // a memory cycle ends on ack or err; the master idles at least one cycle between cycles
        mdone = r.m_cyc & (mem_ack_i | mem_err_i);
        if (mdone) begin
            n.m_cyc = 1'b0;
            stop_e = mem_err_i;
        end

        unique case (r.st)
            ST_IDLE: begin
                // abort is honoured only between chunks so a bus cycle never breaks
                for (int i = 0; i < `NUM_CH; i++) begin
                    if (r.ch[i].cfg[`CFG_EN] && r.ch[i].ctrl[`CTL_ABT]) begin
                        n.ch[i].cfg[`CFG_EN] = 1'b0;
                        n.ch[i].ctrl[`CTL_ABT] = 1'b0;
                        n.ea[8 + i] = 1'b1;
                        n.ch[i].cfg[`CFG_CNT +: 4] = r.ch[i].cfg[`CFG_CNT +: 4] + 4'h1;
                    end
                end
                if (arb_res[3]) begin
                    n.cur = arb_res[2:0];
                    n.last = arb_res[2:0];
                    n.fill = 6'h00;
                    n.drain = 6'h00;
                    n.st = (r.ch[arb_res[2:0]].size[21:0] == 22'h000000) ? ST_DONE : ST_RD;
                end
            end
            ST_RD: begin
                if (!r.m_cyc) begin
                    n.m_cyc = 1'b1;
                    n.m_we = 1'b0;
                    n.m_adr = r.ch[c].src;
                    n.m_sel = r.ch[c].ctrl[`CTL_SSEL];
                end else if (mdone && !mem_err_i) begin
                    n.fifo[r.fill[4:0]] = mem_dat_i;
                    n.fill = r.fill + 6'h01;
                    n.ch[c].size[21:0] = r.ch[c].size[21:0] - 22'h000001;
                    n.ch[c].src = step_addr(r.ch[c].src, r.ch[c].ctrl[`CTL_SAM +: 2]);
                    if (r.ch[c].size[21:0] == 22'h000001 || r.fill == `FIFO_LAST) begin
                        n.st = ST_WR;
                    end
                end
            end
            ST_WR: begin
                if (!r.m_cyc) begin
                    n.m_cyc = 1'b1;
                    n.m_we = 1'b1;
                    n.m_adr = r.ch[c].dst;
                    n.m_dout = r.fifo[r.drain[4:0]];
                    n.m_sel = r.ch[c].ctrl[`CTL_DSEL];
                end else if (mdone && !mem_err_i) begin
                    n.drain = r.drain + 6'h01;
                    n.ch[c].dst = step_addr(r.ch[c].dst, r.ch[c].ctrl[`CTL_DAM +: 2]);
                    if (r.drain + 6'h01 == r.fill) begin
                        n.st = (r.ch[c].size[21:0] == 22'h000000) ? ST_DONE : ST_IDLE;
                    end
                end
            end
            ST_DONE: begin
                n.tc[c] = 1'b1;
                n.ch[c].cfg[`CFG_CNT +: 4] = r.ch[c].cfg[`CFG_CNT +: 4] + 4'h1;
                if (|r.ch[c].nxt[31:2]) begin
                    n.dbase = {r.ch[c].nxt[31:2], 2'b00};
                    n.dsel = r.ch[c].nxt[0];
                    n.widx = `DESC_SRC;
                    n.st = ST_FETCH;
                end else begin
                    n.ch[c].cfg[`CFG_EN] = 1'b0;
                    n.st = ST_IDLE;
                end
            end
            ST_FETCH: begin
                if (!r.m_cyc) begin
                    n.m_cyc = 1'b1;
                    n.m_we = 1'b0;
                    n.m_adr = r.dbase + {27'h0000000, r.widx, 2'b00};
                    n.m_sel = r.dsel;
                end else if (mdone && !mem_err_i) begin
                    unique case (r.widx)
                        `DESC_SRC: n.ch[c].src = mem_dat_i;
                        `DESC_DST: n.ch[c].dst = mem_dat_i;
                        `DESC_NXT: n.ch[c].nxt = mem_dat_i;
                        `DESC_CTL: n.ch[c].ctrl = wmerge(r.ch[c].ctrl, mem_dat_i, `DESC_CTL_MASK);
                        `DESC_SIZE: n.ch[c].size = mem_dat_i & `SIZE_WMASK;
                        default: ;
                    endcase
                    if (r.widx == `DESC_SIZE) begin
                        n.st = ST_IDLE;
                    end else begin
                        n.widx = r.widx + 3'h1;
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase

        if (stop_e && r.st != ST_IDLE) begin
            n.ch[c].cfg[`CFG_EN] = 1'b0;
            n.ea[c] = 1'b1;
            n.ch[c].cfg[`CFG_CNT +: 4] = r.ch[c].cfg[`CFG_CNT +: 4] + 4'h1;
            n.st = ST_IDLE;
        end

        n.irq = 1'b0;
        for (int i = 0; i < `NUM_CH; i++) begin
            n.irq = n.irq | (n.tc[i] & ~n.ch[i].ctrl[`CTL_TCM]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // outputs
    assign wb_dat_o = r.wb_dat;
    assign wb_ack_o = r.wb_ack;
    assign mem_cyc_o = r.m_cyc;
    assign mem_stb_o = r.m_cyc;
    assign mem_we_o = r.m_we;
    assign mem_master_o = r.m_sel;
    assign mem_adr_o = r.m_adr;
    assign mem_dat_o = r.m_dout;
    assign irq_o = r.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_req_reserved: assert property ((r.dreq & ~`REQ_VALID) == 16'h0000)
        else $error("reserved request line seen active");
    a_grant_prio: assert property ((r.st == ST_IDLE && arb_res[3])
        |-> r.ch[arb_res[2:0]].cfg[`CFG_PRI +: 2] == maxpri_f(elig, r.ch))
        else $error("grant below highest requesting priority");
    a_chain_fetch: assert property ((r.st == ST_DONE && |r.ch[c].nxt[31:2])
        |=> r.st == ST_FETCH ##1 (r.m_cyc && r.m_adr == r.dbase))
        else $error("nonzero pointer did not start a fetch");
    a_fetch_master: assert property ((r.st == ST_FETCH && r.m_cyc)
        |-> (r.m_sel == r.dsel && !r.m_we))
        else $error("descriptor fetch on wrong master");
    a_fetch_addr: assert property ((r.st == ST_FETCH && r.m_cyc)
        |-> r.m_adr == r.dbase + {27'h0000000, r.widx, 2'b00})
        else $error("descriptor word address wrong");
    a_chain_end: assert property ((r.st == ST_DONE && r.ch[c].nxt[31:2] == 30'h0)
        |=> (!r.ch[r.cur].cfg[`CFG_EN] && r.st == ST_IDLE))
        else $error("list end did not stop the channel");
    a_desc_load: assert property ((r.st == ST_FETCH && mdone_ok && r.widx == `DESC_NXT)
        |=> r.ch[r.cur].nxt == $past(mem_dat_i))
        else $error("next pointer not copied");
    a_tc_set: assert property (r.st == ST_DONE
        |=> r.tc[r.cur] ##1 (r.irq || r.ch[r.cur].ctrl[`CTL_TCM]))
        else $error("block end did not flag terminal count");
    a_cnt_step: assert property ((r.st == ST_DONE && !(wb_req && r.wb_ack && wb_we_i))
        |=> cur_cnt == 4'($past(cur_cnt) + 4'h1))
        else $error("transaction counter did not step");
    a_err_stop: assert property ((r.st != ST_IDLE && r.m_cyc && mem_err_i)
        |=> (!r.ch[r.cur].cfg[`CFG_EN] && r.st == ST_IDLE && r.ea[r.cur]))
        else $error("bus error did not stop the channel");

endmodule : dma_arbiter_chain_transfer

/* rtl/dma_chain_defines.svh */
// register offsets, field positions and write masks of the dma arbiter and chain engine
`ifndef DMA_CHAIN_DEFINES_SVH
`define DMA_CHAIN_DEFINES_SVH
`define NUM_CH 8
`define TC_STAT_OFS 12'h000
`define TC_CLR_OFS 12'h004
`define EA_STAT_OFS 12'h008
`define EA_CLR_OFS 12'h00C
`define CH_REGION 4'h1
`define CH_CTRL_OFS 5'h00
`define CH_CFG_OFS 5'h04
`define CH_SRC_OFS 5'h08
`define CH_DST_OFS 5'h0C
`define CH_NXT_OFS 5'h10
`define CH_SIZE_OFS 5'h14
`define CTL_WMASK 32'hFFFF8080
`define CFG_WMASK 32'h00003F01
`define SIZE_WMASK 32'h003FFFFF
`define DESC_CTL_MASK 32'hFFFF0000
`define CTL_HW 7
`define CTL_ABT 15
`define CTL_TCM 28
`define CTL_SAM 20
`define CTL_DAM 18
`define CTL_SSEL 17
`define CTL_DSEL 16
`define CFG_EN 0
`define CFG_REQ 8
`define CFG_PRI 12
`define CFG_CNT 16
`define REQ_VALID 16'h006F
`define AM_INC 2'h0
`define AM_DEC 2'h1
`define WORD_STEP 32'h00000004
`define FIFO_LAST 6'h1F
`define DESC_SRC 3'h0
`define DESC_DST 3'h1
`define DESC_NXT 3'h2
`define DESC_CTL 3'h3
`define DESC_SIZE 3'h4
`endif

/* rtl/dma_chain_pkg.sv */
// types of the dma arbiter and chain engine
package dma_chain_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_DONE, ST_FETCH} eng_state_t;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] cfg;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] nxt;
        logic [31:0] size;
    } chan_t;

    typedef struct packed {
        chan_t [7:0] ch;
        logic [31:0][31:0] fifo;
        eng_state_t st;
        logic [2:0] cur;
        logic [2:0] last;
        logic [31:0] dbase;
        logic dsel;
        logic [2:0] widx;
        logic [5:0] fill;
        logic [5:0] drain;
        logic [7:0] tc;
        logic [15:0] ea;
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] s3;
        logic [15:0] dreq;
        logic wb_ack;
        logic [31:0] wb_dat;
        logic m_cyc;
        logic m_we;
        logic m_sel;
        logic [31:0] m_adr;
        logic [31:0] m_dout;
        logic irq;
    } dma_state_t;
endpackage : dma_chain_pkg

/* sim/mem_partner.sv */
// memory partner answering the dma engine's memory master
module mem_partner (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus from the engine
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic master_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // bench controls
    input wire logic [3:0] slow_i,
    input wire logic [31:0] err_adr_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:255];
    logic [31:0] alog [0:1023];
    logic mlog [0:1023];
    int ops;
    logic [3:0] waited;
    // ==========================================================
    // answer logic
    always @(posedge clk_i) begin
        ack_o <= 1'b0;
        err_o <= 1'b0;
        // data line is only valid with ack, so it churns otherwise
        dat_o <= ~dat_o;
        if (rst_i) begin
            waited <= 4'h0;
            ops <= 0;
            dat_o <= 32'h5A5AA5A5;
        end else if (cyc_i && stb_i && !ack_o && !err_o) begin
            if (waited < slow_i) begin
                waited <= waited + 4'h1;
            end else begin
                waited <= 4'h0;
                alog[ops[9:0]] <= adr_i;
                mlog[ops[9:0]] <= master_i;
                ops <= ops + 1;
                if (adr_i == err_adr_i) begin
                    err_o <= 1'b1;
                end else begin
                    ack_o <= 1'b1;
                    if (we_i) begin
                        mem[adr_i[9:2]] <= dat_i;
                    end else begin
                        dat_o <= mem[adr_i[9:2]];
                    end
                end
            end
        end
    end
endmodule : mem_partner

/* sim/dma_arbiter_chain_transfer_tb.sv */
// self-checking bench of the dma arbiter and chain engine
module dma_arbiter_chain_transfer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o, irq;
    logic [11:0] wb_adr;
    logic [3:0] wb_sel, slow;
    logic [31:0] wb_dat, wb_dat_o, q, err_adr, m_adr, m_wdat, m_rdat;
    logic m_cyc, m_stb, m_we, m_mst, m_ack, m_err;
    logic [15:0] dreq;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int o;

    dma_arbiter_chain_transfer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_cyc_o(m_cyc),
        .mem_stb_o(m_stb), .mem_we_o(m_we), .mem_master_o(m_mst), .mem_adr_o(m_adr),
        .mem_dat_o(m_wdat), .mem_dat_i(m_rdat), .mem_ack_i(m_ack), .mem_err_i(m_err),
        .dreq_i(dreq), .irq_o(irq));
    mem_partner mdl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(m_cyc), .stb_i(m_stb), .we_i(m_we),
        .master_i(m_mst), .adr_i(m_adr), .dat_i(m_wdat), .dat_o(m_rdat), .ack_o(m_ack),
        .err_o(m_err), .slow_i(slow), .err_adr_i(err_adr));

    // ==========================================================
    // shared tasks
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk

    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        // no cycle limit here: only the watchdog ends a stuck access
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic setup(input logic [11:0] b, input logic [31:0] s, d, n, sz, c, cfg);
        wb(1'b1, b + 12'h008, s);
        wb(1'b1, b + 12'h00C, d);
        wb(1'b1, b + 12'h010, n);
        wb(1'b1, b + 12'h014, sz);
        wb(1'b1, b, c);
        wb(1'b1, b + 12'h004, cfg);
    endtask : setup

    // polls config until the channel has dropped its enable
    task automatic wait_off(input logic [11:0] cfg);
        int n;
        n = 0;
        do begin
            wb(1'b0, cfg, 32'h0);
            n++;
        end while (q[0] !== 1'b0 && n < 300);
        chk("channel_enable", 32'h0, {31'h0, q[0]});
    endtask : wait_off

    // ==========================================================
    // scenarios
    task automatic t_reset;
        wb(1'b0, 12'h104, 32'h0);
        chk("cfg reset", 32'h0, q);
        wb(1'b1, 12'h0F0, 32'hFFFFFFFF);
        wb(1'b0, 12'h0F0, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("test reset done");
    endtask : t_reset

    task automatic t_chain;
        slow <= 4'h2;
        o = mdl.ops;
        for (int k = 0; k < 3; k++) mdl.mem[64 + k] = 32'hA0000000 + k;
        for (int k = 0; k < 3; k++) mdl.mem[80 + k] = 32'hB0000000 + k;
        // descriptor at 0x200: src, dst, next, control, size
        mdl.mem[128] = 32'h00000140;
        mdl.mem[129] = 32'h000001C0;
        mdl.mem[130] = 32'h0;
        mdl.mem[131] = 32'hE0000000;
        mdl.mem[132] = 32'h00000003;
        setup(12'h100, 32'h100, 32'h180, 32'h201, 32'h2, 32'h0, 32'h1);
        wait_off(12'h104);
        for (int k = 0; k < 2; k++) chk("block1", 32'hA0000000 + k, mdl.mem[96 + k]);
        for (int k = 0; k < 3; k++) chk("block2", 32'hB0000000 + k, mdl.mem[112 + k]);
        for (int k = 0; k < 5; k++) begin
            chk("fetch adr", 32'h200 + 4 * k, mdl.alog[o + 4 + k]);
            chk("fetch master", 32'h1, {31'h0, mdl.mlog[o + 4 + k]});
        end
        wb(1'b0, 12'h104, 32'h0);
        chk("counter", 32'h2, {28'h0, q[19:16]});
        wb(1'b0, 12'h110, 32'h0);
        chk("next ptr", 32'h0, q);
        wb(1'b0, 12'h100, 32'h0);
        chk("control", 32'hE000, {16'h0, q[31:16]});
        wb(1'b0, 12'h000, 32'h0);
        chk("tc status", 32'h1, {24'h0, q[7:0]});
        chk("irq", 32'h1, {31'h0, irq});
        wb(1'b1, 12'h004, 32'h0);
        wb(1'b0, 12'h000, 32'h0);
        chk("tc kept", 32'h1, {24'h0, q[7:0]});
        wb(1'b1, 12'h004, 32'h1);
        wb(1'b0, 12'h000, 32'h0);
        chk("tc cleared", 32'h0, {24'h0, q[7:0]});
        chk("irq off", 32'h0, {31'h0, irq});
        slow <= 4'h0;
        $display("test chain done");
    endtask : t_chain

    task automatic t_error;
        mdl.mem[152] = 32'h0;
        err_adr <= 32'h244;
        setup(12'h100, 32'h240, 32'h260, 32'h0, 32'h2, 32'h0, 32'h1);
        wait_off(12'h104);
        wb(1'b0, 12'h104, 32'h0);
        chk("counter err", 32'h1, {28'h0, q[19:16]});
        wb(1'b0, 12'h008, 32'h0);
        chk("err status", 32'h1, {31'h0, q[0]});
        chk("dst untouched", 32'h0, mdl.mem[152]);
        err_adr <= 32'hFFFFFFFC;
        wb(1'b1, 12'h00C, 32'h1);
        $display("test error done");
    endtask : t_error

    // a block longer than the staging buffer must drain after 32 reads
    task automatic t_fifo;
        o = mdl.ops;
        for (int k = 0; k < 34; k++) mdl.mem[k] = 32'hC0000000 + k;
        setup(12'h180, 32'h0, 32'h300, 32'h0, 32'h22, 32'h0, 32'h1);
        wait_off(12'h184);
        chk("last read before drain", 32'h7C, mdl.alog[o + 31]);
        chk("first write", 32'h300, mdl.alog[o + 32]);
        for (int k = 0; k < 34; k++) begin
            chk("long block", 32'hC0000000 + k, mdl.mem[192 + k]);
        end
        wb(1'b0, 12'h184, 32'h0);
        chk("counter one block", 32'h1, {28'h0, q[19:16]});
        $display("test fifo done");
    endtask : t_fifo

    task automatic t_prio;
        setup(12'h120, 32'h300, 32'h380, 32'h0, 32'h1, 32'h80, 32'h0501);
        setup(12'h140, 32'h340, 32'h3A0, 32'h0, 32'h1, 32'h80, 32'h3501);
        setup(12'h160, 32'h3C0, 32'h3E0, 32'h0, 32'h1, 32'h80, 32'h0401);
        o = mdl.ops;
        repeat (10) @(posedge clk_i);
        chk("idle without request", o, mdl.ops);
        dreq <= 16'h0030;
        wait_off(12'h144);
        wait_off(12'h124);
        chk("winner", 32'h340, mdl.alog[o]);
        wb(1'b0, 12'h164, 32'h0);
        chk("reserved line", 32'h1, {31'h0, q[0]});
        dreq <= 16'h0;
        wb(1'b1, 12'h164, 32'h0);
        $display("test priority done");
    endtask : t_prio

    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles >= 20000) begin
            fails++;
            $display("[FAIL] run length expected below 20000 seen %0d", cycles);
            close_out();
        end
    end

    initial begin
        {rst_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} = '0;
        rst_i = 1'b1;
        wb_sel = 4'hF;
        slow = 4'h0;
        dreq = 16'h0;
        err_adr = 32'hFFFFFFFC;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_chain();
        t_error();
        t_fifo();
        t_prio();
        close_out();
    end
endmodule : dma_arbiter_chain_transfer_tb
